/* rtl/bbs_supervisor.sv */
// Summary of operation
// - Sealed: battery isolated; seal ends on first reset release after power returns.
// - Battery sampled every 200 ms, divider load applied only for short on-time.
// - Battery measurement schedule runs only after reset is released.
// - Low battery at a measurement drives good flag low; otherwise flag holds.
// - Reset released: chip-select gate enabled, input passes to output.
// - Reset asserted: chip-select path disabled, output held high.
// - Reset asserting with chip-select high disables gate immediately.
// - Chip-select low at reset: disable on its rise or after 15 us.
// - Disable mode pulls chip-select output high; pull-up off when enabled.
// - Aux fail out low below reference, high again only above hysteresis.
// - Low-line warning high normally, low when supply under low-line level.
// - Backup-active output high exactly while supply output uses battery.
// - Battery selected automatically only if supply under threshold and not above battery.
// - Return to main once supply exceeds battery or threshold, whichever first.
// - Force input moves main mode to backup; backup then ignores force input.
// - Any kick edge, rising or falling, restarts the watchdog from zero.
// - Unconnected kick pin: watchdog retriggers itself and never times out.
// - Self-retrigger drives kick low for 7/8 timeout, then a brief high pulse.
// - Reset held while supply under threshold, released after internal delay.
`timescale 1ns/1ps
`default_nettype none
module bbs_supervisor
  import bbs_pkg::*;
#(
  parameter int unsigned RST_DELAY = RST_DELAY_CYC,
  parameter int unsigned BAT_PERIOD = BAT_PERIOD_CYC,
  parameter int unsigned WD_TIMEOUT = WD_TIMEOUT_CYC,
  parameter int unsigned SEAL_MIN = SEAL_MIN_CYC,
  parameter int unsigned SEAL_MAX = SEAL_MAX_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic vdd_above_thr_i,
  input wire logic vdd_above_lowline_i,
  input wire logic vdd_above_bat_i,
  input wire logic bat_above_ok_i,
  input wire logic aux_fail_in_above_ref_i,
  input wire logic aux_fail_in_above_hyst_i,
  input wire logic aux_fail_pin_i,
  input wire logic force_backup_in_i,
  input wire logic chip_sel_in_i,
  input wire logic watchdog_kick_in_i,
  output logic watchdog_kick_out_o,
  output logic watchdog_kick_oe_n_o,
  output logic reset_n_o,
  output logic chip_sel_out_o,
  output logic chip_sel_pullup_o,
  output logic supply_sel_bat_o,
  output logic backup_active_out_o,
  output logic aux_fail_out_o,
  output logic lowline_n_o,
  output logic battery_good_flag_o,
  output logic bat_load_on_o,
  output logic bat_isolated_o,
  output logic wdog_timeout_o
);

  localparam int unsigned WD_SELF = (WD_TIMEOUT / 8) * 7;

  // ----------------------------------------------------------------
  // Condition synchroniser
  // ----------------------------------------------------------------
  logic [COND_W-1:0] cond_raw;
  logic [COND_W-1:0] cond;

  assign cond_raw = {aux_fail_in_above_hyst_i, aux_fail_in_above_ref_i, bat_above_ok_i,
                     vdd_above_bat_i, vdd_above_lowline_i, vdd_above_thr_i};

  bbs_cond_sync u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .cond_i(cond_raw),
    .cond_o(cond)
  );

  logic vdd_thr;
  logic vdd_bat;
  logic aux_ref;
  logic seal_cond;

  assign vdd_thr = cond[COND_VDD_THR];
  assign vdd_bat = cond[COND_VDD_BAT];
  assign aux_ref = cond[COND_AUX_REF];
  // Board grounds the fail output while the aux input sits at supply
  assign seal_cond = !aux_fail_pin_i && aux_ref;

  bbs_state_s s;
  bbs_state_s next_s;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.wd_to = 1'b0;

    // Reset generator
    if (!vdd_thr) begin
      next_s.rst_n = 1'b0;
      next_s.rst_cnt = 32'h0;
    end else if (!s.rst_n) begin
      if (s.rst_cnt >= RST_DELAY - 1) begin
        next_s.rst_n = 1'b1;
      end else begin
        next_s.rst_cnt = s.rst_cnt + 32'h1;
      end
    end

    // Chip-select gate, driven by the registered reset
    unique case (s.cs)
      CS_EN: begin
        if (!s.rst_n) begin
          if (chip_sel_in_i) begin
            next_s.cs = CS_DIS;
          end else begin
            next_s.cs = CS_GRACE;
            next_s.cs_cnt = 32'h0;
          end
        end
      end
      CS_GRACE: begin
        // Lets a write cycle in flight finish during power-down
        if (s.rst_n) begin
          next_s.cs = CS_EN;
        end else if (chip_sel_in_i || s.cs_cnt >= CS_GRACE_CYC - 1) begin
          next_s.cs = CS_DIS;
        end else begin
          next_s.cs_cnt = s.cs_cnt + 32'h1;
        end
      end
      CS_DIS: begin
        if (s.rst_n) begin
          next_s.cs = CS_EN;
        end
      end
      default: next_s.cs = CS_DIS;
    endcase
    next_s.cs_pull = (next_s.cs == CS_DIS);
    next_s.cs_out = next_s.cs_pull ? 1'b1 : chip_sel_in_i;

    // Freshness seal
    unique case (s.seal)
      SL_IDLE: begin
        if (!s.rst_n && vdd_thr && seal_cond) begin
          next_s.seal = SL_ARM;
          next_s.seal_cnt = 32'h1;
        end
      end
      SL_ARM: begin
        if (next_s.rst_n) begin
          next_s.seal = SL_IDLE;
        end else if (vdd_thr && seal_cond) begin
          if (s.seal_cnt <= SEAL_MAX) begin
            next_s.seal_cnt = s.seal_cnt + 32'h1;
          end
        end else if (!vdd_thr && s.seal_cnt >= SEAL_MIN && s.seal_cnt <= SEAL_MAX) begin
          next_s.seal = SL_SEALED;
        end else begin
          next_s.seal = SL_IDLE;
        end
      end
      SL_SEALED: begin
        if (next_s.rst_n && !s.rst_n) begin
          next_s.seal = SL_IDLE;
        end
      end
      default: next_s.seal = SL_IDLE;
    endcase
    next_s.iso = (next_s.seal == SL_SEALED);

    // Supply selection; an isolated battery is never switched in
    if (next_s.iso) begin
      next_s.bat_sel = 1'b0;
      next_s.forced = 1'b0;
    end else begin
      if (!vdd_thr) begin
        next_s.forced = 1'b0;
      end else if (!s.bat_sel && force_backup_in_i) begin
        next_s.forced = 1'b1;
      end
      next_s.bat_sel = (!vdd_thr && !vdd_bat) || next_s.forced;
    end

    // Power-fail and low-line comparators
    if (!aux_ref) begin
      next_s.aux_ok = 1'b0;
    end else if (cond[COND_AUX_HYST]) begin
      next_s.aux_ok = 1'b1;
    end
    next_s.lowline_n = cond[COND_VDD_LL];

    // Battery check
    if (!s.rst_n) begin
      next_s.bat_cnt = 32'h0;
      next_s.bat_load = 1'b0;
    end else begin
      if (s.bat_load && s.bat_cnt == BAT_ON_CYC - 1 && !cond[COND_BAT_OK]) begin
        next_s.bat_good = 1'b0;
      end
      next_s.bat_cnt = (s.bat_cnt >= BAT_PERIOD - 1) ? 32'h0 : s.bat_cnt + 32'h1;
      next_s.bat_load = (next_s.bat_cnt < BAT_ON_CYC);
    end

    // Watchdog with self-retrigger through the weakly driven kick pin
    next_s.kick_q = watchdog_kick_in_i;
    if (!s.rst_n) begin
      next_s.wd_cnt = 32'h0;
    end else if (watchdog_kick_in_i != s.kick_q) begin
      next_s.wd_cnt = 32'h0;
    end else if (s.wd_cnt >= WD_TIMEOUT - 1) begin
      next_s.wd_cnt = 32'h0;
      next_s.wd_to = 1'b1;
    end else begin
      next_s.wd_cnt = s.wd_cnt + 32'h1;
    end
    next_s.kick_drv = (next_s.wd_cnt >= WD_SELF);
    next_s.kick_oe_n = 1'b0;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reset_n_o = s.rst_n;
  assign chip_sel_out_o = s.cs_out;
  assign chip_sel_pullup_o = s.cs_pull;
  assign supply_sel_bat_o = s.bat_sel;
  assign backup_active_out_o = s.bat_sel;
  assign aux_fail_out_o = s.aux_ok;
  assign lowline_n_o = s.lowline_n;
  assign battery_good_flag_o = s.bat_good;
  assign bat_load_on_o = s.bat_load;
  assign bat_isolated_o = s.iso;
  assign watchdog_kick_out_o = s.kick_drv;
  assign watchdog_kick_oe_n_o = s.kick_oe_n;
  assign wdog_timeout_o = s.wd_to;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_reset_hold_low:
    assert property (!vdd_thr |=> !reset_n_o)
    else $error("reset released while supply under threshold");

  a_cs_pass_through:
    assert property ((s.rst_n && s.cs == CS_EN) |=> chip_sel_out_o == $past(chip_sel_in_i))
    else $error("chip-select not passed while enabled");

  a_cs_fast_disable:
    assert property ((!s.rst_n && s.cs == CS_EN && chip_sel_in_i) |=> chip_sel_pullup_o)
    else $error("gate not disabled at once with chip-select high");

  a_cs_grace_limit:
    assert property ((s.cs == CS_GRACE) |-> s.cs_cnt < CS_GRACE_CYC)
    else $error("grace period overran");

  a_cs_pullup_high:
    assert property (chip_sel_pullup_o |-> chip_sel_out_o && !reset_n_o || $rose(reset_n_o))
    else $error("pull-up active but output not high");

  a_aux_fail_low:
    assert property (!aux_ref |=> !aux_fail_out_o)
    else $error("fail output not low under reference");

  a_auto_to_battery:
    assert property ((!vdd_thr && !vdd_bat && !next_s.iso) |=> backup_active_out_o)
    else $error("battery not selected on supply loss");

  a_force_holds:
    // Supply loss clears the forced mode, so the second cycle only counts with supply up
    assert property ((s.forced && vdd_thr && !next_s.iso) |=>
                     backup_active_out_o ##1 (backup_active_out_o || !$past(vdd_thr)))
    else $error("forced backup mode not held");

  a_seal_isolates:
    assert property (bat_isolated_o |-> !backup_active_out_o)
    else $error("battery switched in while sealed");

  a_load_after_reset:
    assert property (bat_load_on_o |-> $past(reset_n_o))
    else $error("battery load before reset release");

  a_load_on_time:
    assert property (bat_load_on_o |-> s.bat_cnt < BAT_ON_CYC)
    else $error("battery load on too long");

  a_flag_never_rises:
    assert property (!battery_good_flag_o |=> !battery_good_flag_o)
    else $error("battery flag rose");

  a_kick_restart:
    assert property ((s.rst_n && vdd_thr && watchdog_kick_in_i != s.kick_q) |=> s.wd_cnt == 32'h0)
    else $error("kick edge did not restart watchdog");

  a_kick_low_early:
    assert property (watchdog_kick_out_o |-> s.wd_cnt >= WD_SELF)
    else $error("self kick driven high before 7/8 timeout");

endmodule : bbs_supervisor
`default_nettype wire

/* include/bbs_pkg.sv */
`default_nettype none
package bbs_pkg;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned NS_PER_US = 1000;
  localparam int unsigned NS_PER_MS = 1000000;

  // ----------------------------------------------------------------
  // Times in their own units
  // ----------------------------------------------------------------
  localparam int unsigned RST_DELAY_MS = 50;
  localparam int unsigned BAT_PERIOD_MS = 200;
  localparam int unsigned BAT_ON_US = 25;
  localparam int unsigned CS_GRACE_US = 15;
  localparam int unsigned WD_TIMEOUT_MS = 800;
  localparam int unsigned SEAL_MIN_MS = 5;
  localparam int unsigned SEAL_MAX_MS = 35;

  // ----------------------------------------------------------------
  // Cycle counts: least times round up, longest times round down
  // ----------------------------------------------------------------
  localparam int unsigned RST_DELAY_CYC =
    (RST_DELAY_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BAT_PERIOD_CYC = (BAT_PERIOD_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int unsigned BAT_ON_CYC =
    (BAT_ON_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CS_GRACE_CYC =
    (CS_GRACE_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WD_TIMEOUT_CYC = (WD_TIMEOUT_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int unsigned SEAL_MIN_CYC =
    (SEAL_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SEAL_MAX_CYC = (SEAL_MAX_MS * NS_PER_MS) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Condition inputs, bit positions
  // ----------------------------------------------------------------
  localparam int COND_W = 6;
  localparam int COND_VDD_THR = 0;
  localparam int COND_VDD_LL = 1;
  localparam int COND_VDD_BAT = 2;
  localparam int COND_BAT_OK = 3;
  localparam int COND_AUX_REF = 4;
  localparam int COND_AUX_HYST = 5;
  localparam logic [COND_W-1:0] COND_RST = 6'h00;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CS_EN = 3'b001,
    CS_GRACE = 3'b010,
    CS_DIS = 3'b100
  } bbs_cs_e;

  typedef enum logic [2:0] {
    SL_IDLE = 3'b001,
    SL_ARM = 3'b010,
    SL_SEALED = 3'b100
  } bbs_seal_e;

  typedef struct packed {
    logic rst_n;
    logic [31:0] rst_cnt;
    bbs_cs_e cs;
    logic [31:0] cs_cnt;
    logic cs_out;
    logic cs_pull;
    logic bat_sel;
    logic forced;
    logic aux_ok;
    logic lowline_n;
    logic bat_good;
    logic bat_load;
    logic [31:0] bat_cnt;
    logic [31:0] wd_cnt;
    logic kick_q;
    logic kick_drv;
    logic kick_oe_n;
    logic wd_to;
    bbs_seal_e seal;
    logic [31:0] seal_cnt;
    logic iso;
  } bbs_state_s;

  localparam bbs_state_s STATE_RST = '{
    rst_n: 1'b0, rst_cnt: 32'h0, cs: CS_DIS, cs_cnt: 32'h0, cs_out: 1'b1,
    cs_pull: 1'b1, bat_sel: 1'b0, forced: 1'b0, aux_ok: 1'b0, lowline_n: 1'b0,
    bat_good: 1'b1, bat_load: 1'b0, bat_cnt: 32'h0, wd_cnt: 32'h0, kick_q: 1'b0,
    kick_drv: 1'b0, kick_oe_n: 1'b0, wd_to: 1'b0, seal: SL_IDLE, seal_cnt: 32'h0,
    iso: 1'b0
  };

endpackage : bbs_pkg
`default_nettype wire

/* rtl/bbs_cond_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module bbs_cond_sync
  import bbs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [COND_W-1:0] cond_i,
  output logic [COND_W-1:0] cond_o
);

  typedef struct packed {
    logic [COND_W-1:0] meta;
    logic [COND_W-1:0] stable;
  } bbs_sync_s;

  bbs_sync_s s;
  bbs_sync_s next_s;

  // First stage feeds only the second stage
  always_comb begin
    next_s.meta = cond_i;
    next_s.stable = s.meta;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '{meta: COND_RST, stable: COND_RST};
    end else begin
      s <= next_s;
    end
  end

  assign cond_o = s.stable;

endmodule : bbs_cond_sync
`default_nettype wire

/* dv/bbs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bbs_host_model (
  input wire logic mclk_i,
  input wire logic host_drv_i,
  input wire logic [7:0] host_period_i,
  input wire logic kick_out_i,
  input wire logic kick_oe_n_i,
  output logic kick_o
);
  logic host_lvl = 1'b0;
  logic last = 1'b0;
  logic [7:0] cnt = 8'h00;

  // ------------------------------------------------------------
  // Host kick, one level flip per period; zero period holds low
  // ------------------------------------------------------------
  always @(posedge mclk_i) begin
    last <= kick_o;
    if (!host_drv_i || host_period_i == 8'h00) begin
      cnt <= 8'h00;
      host_lvl <= 1'b0;
    end else if (cnt >= host_period_i - 8'h01) begin
      cnt <= 8'h00;
      host_lvl <= ~host_lvl;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  // Host driver wins over the weak self-drive; a released pin has no fixed level
  always_comb begin
    if (host_drv_i) kick_o = host_lvl;
    else if (!kick_oe_n_i) kick_o = kick_out_i;
    else kick_o = ~last;
  end
endmodule : bbs_host_model
`default_nettype wire

/* dv/battery_backup_supervisor_logic_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module battery_backup_supervisor_logic_tb;
  import bbs_pkg::*;
  localparam int RD = 60;
  logic mclk = 1'b0, rst_n = 1'b0;
  logic thr = 1'b0, ll = 1'b0, abat = 1'b0, bok = 1'b1, aref = 1'b0, ahys = 1'b0;
  logic pin_lvl = 1'b1, force_b = 1'b0, cs_in = 1'b1, host_drv = 1'b0;
  logic [7:0] host_per = 8'h00;
  logic kick, kick_out, kick_oe_n, rst_o, cs_out, cs_pu, sel, bkp;
  logic aux_o, ll_o, flag, load, iso, wto;
  int fails = 0, n_tests = 0, c, c2, k;
  // {thr, above_bat, lowline, aux_ref, aux_hyst, exp_sel, exp_lowline, exp_aux}
  logic [7:0] rows [6] = '{8'h04, 8'h50, 8'h99, 8'hf3, 8'ha2, 8'h04};

  always #4 mclk = ~mclk;

  bbs_supervisor #(.RST_DELAY(RD), .BAT_PERIOD(4000), .WD_TIMEOUT(64), .SEAL_MIN(10),
    .SEAL_MAX(40)) u_dut (.mclk_i(mclk), .rst_n_i(rst_n), .vdd_above_thr_i(thr),
    .vdd_above_lowline_i(ll), .vdd_above_bat_i(abat), .bat_above_ok_i(bok),
    .aux_fail_in_above_ref_i(aref), .aux_fail_in_above_hyst_i(ahys), .aux_fail_pin_i(pin_lvl),
    .force_backup_in_i(force_b), .chip_sel_in_i(cs_in), .watchdog_kick_in_i(kick),
    .watchdog_kick_out_o(kick_out), .watchdog_kick_oe_n_o(kick_oe_n), .reset_n_o(rst_o),
    .chip_sel_out_o(cs_out), .chip_sel_pullup_o(cs_pu), .supply_sel_bat_o(sel),
    .backup_active_out_o(bkp), .aux_fail_out_o(aux_o), .lowline_n_o(ll_o),
    .battery_good_flag_o(flag), .bat_load_on_o(load), .bat_isolated_o(iso),
    .wdog_timeout_o(wto));

  bbs_host_model u_host (.mclk_i(mclk), .host_drv_i(host_drv), .host_period_i(host_per),
    .kick_out_i(kick_out), .kick_oe_n_i(kick_oe_n), .kick_o(kick));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic sig(input int w);
    case (w)
      0: return rst_o;
      1: return cs_pu;
      2: return load;
      3: return wto;
      4: return iso;
      6: return kick_out;
      default: return flag;
    endcase
  endfunction : sig

  // Bounded wait; a hang counts as a mismatch and closes the run
  task automatic wait_sig(input int w, input logic v, input int max, output int n);
    n = 0;
    while (sig(w) !== v) begin
      step(1);
      n++;
      if (n > max) begin
        fails++;
        $display("ERROR t=%0t wait %h got=%h exp=%h", $time, w, sig(w), v);
        print_verdict();
      end
    end
  endtask : wait_sig

  task automatic reset_up();
    thr = 1'b1;
    wait_sig(0, 1'b1, RD + 10, c);
  endtask : reset_up

  task automatic print_verdict();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    step(6);
    chk({cs_out, cs_pu, rst_o, flag, load, iso}, 32'h34);
    rst_n = 1'b1;
    step(1);
    foreach (rows[i]) begin
      {thr, abat, ll, aref, ahys} = rows[i][7:3];
      step(5);
      chk(load, 1'b0);
      chk({sel, bkp}, {2{rows[i][2]}});
      chk(ll_o, rows[i][1]);
      chk(aux_o, rows[i][0]);
    end
    $display("test rows done");
    {abat, ll, aref, ahys} = 4'hf;
    reset_up();
    chk(32'(c >= RD && c <= RD + 4), 32'h1);
    wait_sig(2, 1'b1, 4, c);
    wait_sig(2, 1'b0, 3200, c);
    chk(32'(c >= 3123 && c <= 3126), 32'h1);
    wait_sig(2, 1'b1, 1000, c2);
    chk(32'(c + c2 >= 3998 && c + c2 <= 4001), 32'h1);
    chk(flag, 1'b1);
    bok = 1'b0;
    wait_sig(7, 1'b0, 4100, c);
    bok = 1'b1;
    step(4100);
    chk(flag, 1'b0);
    $display("test battery done");
    for (k = 0; k < 3; k++) begin
      cs_in = k[0];
      step(2);
      chk({cs_out, cs_pu}, {k[0], 1'b0});
    end
    $display("test chip select pass done");
    c2 = 0;
    repeat (600) begin
      step(1);
      if (wto === 1'b1) c2++;
    end
    chk(c2, 0);
    chk(kick_oe_n, 1'b0);
    // Align to a self-kick pulse so the low time is measured from its end
    wait_sig(6, 1'b1, 100, c);
    wait_sig(6, 1'b0, 100, c);
    wait_sig(6, 1'b1, 100, c);
    chk(32'(c >= 53 && c <= 60), 32'h1);
    host_drv = 1'b1;
    wait_sig(3, 1'b1, 80, c);
    step(1);
    wait_sig(3, 1'b1, 80, c);
    chk(32'(c >= 62 && c <= 65), 32'h1);
    host_per = 8'h28;
    step(50);
    c2 = 0;
    repeat (400) begin
      step(1);
      if (wto === 1'b1) c2++;
    end
    chk(c2, 0);
    host_drv = 1'b0;
    $display("test watchdog done");
    force_b = 1'b1;
    step(4);
    chk({sel, bkp}, 2'h3);
    force_b = 1'b0;
    step(4);
    chk(sel, 1'b1);
    {thr, abat} = 2'h0;
    step(5);
    chk(sel, 1'b1);
    abat = 1'b1;
    step(4);
    chk({sel, bkp}, 2'h0);
    $display("test switchover done");
    reset_up();
    cs_in = 1'b1;
    thr = 1'b0;
    wait_sig(0, 1'b0, 6, c);
    wait_sig(1, 1'b1, 3, c);
    chk({cs_out, cs_pu}, 2'h3);
    for (k = 0; k < 2; k++) begin
      reset_up();
      cs_in = 1'b0;
      step(2);
      thr = 1'b0;
      wait_sig(0, 1'b0, 6, c);
      if (k == 1) begin
        step(100);
        cs_in = 1'b1;
        wait_sig(1, 1'b1, 4, c);
      end else begin
        wait_sig(1, 1'b1, 2000, c);
        chk(32'(c >= 1874 && c <= 1879), 32'h1);
      end
    end
    $display("test chip select gate done");
    pin_lvl = 1'b0;
    step(4);
    thr = 1'b1;
    step(4);
    thr = 1'b0;
    step(8);
    chk(iso, 1'b0);
    thr = 1'b1;
    step(20);
    thr = 1'b0;
    wait_sig(4, 1'b1, 8, c);
    pin_lvl = 1'b1;
    thr = 1'b1;
    step(RD / 2);
    chk(iso, 1'b1);
    wait_sig(0, 1'b1, RD + 10, c);
    wait_sig(4, 1'b0, 3, c);
    $display("test seal done");
    print_verdict();
  end
endmodule : battery_backup_supervisor_logic_tb
`default_nettype wire
